// File: bench/ssc_codec.sv
`timescale 1ns/1ns

// ======================================
// codec model, one link clock for both directions, still between frames
module ssc_codec (
   output logic      lclk_out,
   output logic      sync_out,
   output logic      data_out,
   input  wire logic tx_data_in
);
   initial begin
      lclk_out = 1'b0;
      sync_out = 1'b0;
      data_out = 1'b0;
   end

   // sync high across one rising link clock edge, then n data bits msb first
   task automatic frame(input logic [31:0] w, input int n, output logic [31:0] t);
      t = 32'h00000000;
      sync_out = 1'b1;
      #40 lclk_out = 1'b1;
      #80 lclk_out = 1'b0;
      sync_out = 1'b0;
      data_out = w[n-1];
      for (int i = 1; i <= n; i++) begin
         #80 lclk_out = 1'b1;
         #80 lclk_out = 1'b0;
         // sampled just before the device moves its line again
         t = {t[30:0], tx_data_in};
         // released line shows the inverse so no stale bit passes for data
         data_out = (i < n) ? w[n-1-i] : ~data_out;
      end
      #80;
   endtask
endmodule

// File: bench/testbench.sv
`timescale 1ns/1ns

// ======================================
// bench top
module testbench;
   logic        clk_in;
   logic        sys_rst_in;
   logic [7:0]  addr_in;
   logic [31:0] wr_data_in;
   logic        wr_en_in;
   logic        rd_en_in;
   logic [31:0] rd_data_out;
   logic        lclk;
   logic        lsync;
   logic        ldata;
   logic        tx_data_out;
   logic        irq_out;
   logic        ce;
   int          seed;
   int          failures = 0;
   int          samples_checked = 0;
   logic [31:0] r;
   logic [31:0] m;
   logic [31:0] w1;
   logic [31:0] w2;
   logic [31:0] tw;
   logic [31:0] t;
   logic [7:0]  ofs [8] = '{8'h20, 8'h30, 8'h34, 8'h38, 8'h3C, 8'h40, 8'h4C, 8'h50};

   ssc_ctrl i_ssc_ctrl (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .ce_in(ce),
      .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_en_in(wr_en_in),
      .rd_en_in(rd_en_in), .rd_data_out(rd_data_out), .rx_clock_in(lclk),
      .rx_sync_in(lsync), .rx_data_in(ldata), .tx_clock_in(lclk),
      .tx_sync_in(lsync), .tx_data_out(tx_data_out), .irq_out(irq_out));

   ssc_codec i_ssc_codec (.lclk_out(lclk), .sync_out(lsync), .data_out(ldata),
      .tx_data_in(tx_data_out));

   initial begin
      clk_in = 1'b0;
      forever #10 clk_in = ~clk_in;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      addr_in <= a;
      wr_data_in <= d;
      wr_en_in <= 1'b1;
      @(posedge clk_in);
      wr_en_in <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk_in);
      addr_in <= a;
      rd_en_in <= 1'b1;
      @(posedge clk_in);
      rd_en_in <= 1'b0;
      #1 chk(rd_data_out, exp);
   endtask

   task automatic print_verdict;
      $display("checked %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   initial begin
      #200000;
      failures++;
      print_verdict;
   end

   initial begin
      seed = 32'h2329cefd;
      addr_in = 8'h00;
      wr_data_in = 32'h00000000;
      wr_en_in = 1'b0;
      rd_en_in = 1'b0;
      ce = 1'b1;
      sys_rst_in = 1'b1;
      repeat (16) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      foreach (ofs[i]) rchk(ofs[i], (ofs[i] == 8'h40) ? 32'h3 : 32'h0);
      for (int i = 2; i < 5; i++) begin
         r = $random(seed);
         wr(ofs[i], r);
         rchk(ofs[i], r & 32'h0000FFFF);
      end
      r = $random(seed);
      wr(8'h44, r);
      m = r & 32'h00000F33;
      rchk(8'h4C, m);
      r = $random(seed);
      wr(8'h48, r);
      m = m & ~r;
      rchk(8'h4C, m);
      // a strobe while the clock enable is low must leave the mask alone
      @(posedge clk_in) ce <= 1'b0;
      wr(8'h44, 32'h00000F33);
      ce <= 1'b1;
      rchk(8'h4C, m);
      wr(8'h48, 32'hFFFFFFFF);
      wr(8'h44, 32'h00000001);
      #1 chk({31'h0, irq_out}, 32'h1);
      wr(8'h48, 32'h00000001);
      wr(8'h44, 32'h00000010);
      #1 chk({31'h0, irq_out}, 32'h0);
      wr(8'h0C, 32'h00000007);
      wr(8'h1C, 32'h00000007);
      w1 = $random(seed) & 32'h000000FF;
      w2 = w1 ^ 32'h0000005A;
      wr(8'h38, w1);
      wr(8'h3C, w2);
      wr(8'h00, 32'h00000101);
      rchk(8'h40, 32'h00030003);
      // upper bits are junk on purpose: only the low word length bits go out
      tw = $random(seed);
      wr(8'h24, tw);
      rchk(8'h40, 32'h00030000);
      i_ssc_codec.frame(w1, 8, t);
      repeat (20) @(posedge clk_in);
      #1 chk({31'h0, irq_out}, 32'h1);
      chk(t, tw & 32'h000000FF);
      rchk(8'h40, 32'h00030D13);
      rchk(8'h40, 32'h00030013);
      rchk(8'h20, w1);
      rchk(8'h40, 32'h00030003);
      // one sync bit goes ahead of the word; its last data bit leaves in the next frame
      r = $random(seed);
      wr(8'h34, r);
      tw = $random(seed);
      wr(8'h24, tw);
      wr(8'h1C, 32'h00800007);
      i_ssc_codec.frame(w2, 8, t);
      chk(t, {24'h000000, r[0], tw[7:1]});
      i_ssc_codec.frame(w2, 8, t);
      repeat (20) @(posedge clk_in);
      rchk(8'h40, 32'h00030E33);
      rchk(8'h20, w2);
      wr(8'h00, 32'h00000202);
      repeat (4) @(posedge clk_in);
      rchk(8'h40, 32'h00000003);
      print_verdict;
   end
endmodule

// File: rtl/ssc_consts.svh
`ifndef SSC_CONSTS_SVH
`define SSC_CONSTS_SVH

// ======================================
// register offsets
`define SSC_CMD_OFS 8'h00
`define SSC_RFM_OFS 8'h0C
`define SSC_TFM_OFS 8'h1C
`define SSC_RXW_OFS 8'h20
`define SSC_TXW_OFS 8'h24
`define SSC_RSW_OFS 8'h30
`define SSC_TSW_OFS 8'h34
`define SSC_RC0_OFS 8'h38
`define SSC_RC1_OFS 8'h3C
`define SSC_SR_OFS  8'h40
`define SSC_IES_OFS 8'h44
`define SSC_IEC_OFS 8'h48
`define SSC_IEM_OFS 8'h4C

// ======================================
// status and mask bit positions
`define SSC_SR_TRANSMIT_READY_FLAG 0
`define SSC_SR_TXEMP 1
`define SSC_SR_RECEIVE_READY_FLAG 4
`define SSC_SR_RECEIVE_OVERRUN_FLAG 5
`define SSC_SR_CP0   8
`define SSC_SR_CP1   9
`define SSC_SR_TRANSMIT_FRAME_SYNC_FLAG 10
`define SSC_SR_RECEIVE_FRAME_SYNC_FLAG 11
`define SSC_SR_TRANSMITTER_ENABLED  16
`define SSC_SR_RECEIVER_ENABLED  17
`define SSC_IRQ_BITS 32'h00000F33

// ======================================
// command and frame mode fields
`define SSC_CMD_RECEIVER_ENABLED  0
`define SSC_CMD_RECEIVER_DISABLE_CMD 1
`define SSC_CMD_TRANSMITTER_ENABLED  8
`define SSC_CMD_TRANSMITTER_DISABLE_CMD 9
`define SSC_LEN_HI    4
`define SSC_SLEN_HI   19
`define SSC_SLEN_LO   16
`define SSC_SYNC_DATA_ENABLE     23

// ======================================
// reset values
`define SSC_RST_WORD  32'h00000000
`define SSC_RST_HALF  16'h0000

`endif

// File: rtl/ssc_ctrl.sv
`timescale 1ns/1ns
`include "ssc_consts.svh"

// Function
// RL1 - received word is right-justified in receive_word, bit 0 least significant
// RL2 - software writes transmit_word right-justified; low bits are sent
// RL3 - receive-enable flag set by command, cleared after disable once idle
// RL4 - transmit-enable flag set by command, cleared after disable once idle
// RL5 - receive sync flag set on receive frame sync, cleared by status read
// RL6 - transmit sync flag set on transmit frame sync, cleared by status read
// RL7 - compare-one flag set on compare-one event, cleared by status read
// RL8 - compare-zero flag set on compare-zero event, cleared by status read
// RL9 - overrun flag set when unread receive_word is overwritten, cleared by status read
// RL10 - receive ready set on word load, dropped when receive_word is read
// RL11 - transmit drained only when holding register empty and shifter done
// RL12 - transmit ready while holding register empty, dropped on load
// RL13 - writing ones to irq_enable_set sets those mask bits only
// RL14 - writing ones to irq_enable_clear clears those mask bits only
// RL15 - mask bit one enables its source; mask is readable
// RL16 - with sync data enable, sync word is shifted out during frame sync
// RL17 - data words carry word length field plus one bits
// RL18 - interrupt high while any flag is set with its mask bit set
module ssc_ctrl
   import ssc_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        sys_rst_in,
   input  wire logic        ce_in,
   input  wire logic [7:0]  addr_in,
   input  wire logic [31:0] wr_data_in,
   input  wire logic        wr_en_in,
   input  wire logic        rd_en_in,
   output logic      [31:0] rd_data_out,
   input  wire logic        rx_clock_in,
   input  wire logic        rx_sync_in,
   input  wire logic        rx_data_in,
   input  wire logic        tx_clock_in,
   input  wire logic        tx_sync_in,
   output logic             tx_data_out,
   output logic             irq_out
);

   // ======================================
   // helpers
   function automatic logic word_hit(input logic [31:0] w, input logic [15:0] c);
      word_hit = (w[15:0] == c);
   endfunction

   function automatic logic acc(input logic en, input logic [7:0] a, input logic [7:0] o);
      acc = en && (a == o);
   endfunction

   // ======================================
   // declarations
   logic [4:0]  pins;
   logic        rxc_l;
   logic        rxs_l;
   logic        rxd_l;
   logic        txc_l;
   logic        txs_l;
   logic [31:0] rx_sr;
   logic        rx_load;
   logic [15:0] rx_sync_word;
   logic        rx_frame;
   logic        rx_busy;
   logic [31:0] rfm;
   logic [31:0] tfm;
   logic [31:0] receive_word;
   logic [31:0] transmit_word;
   logic [31:0] shifter;
   logic [15:0] transmit_sync_word;
   logic [15:0] cmp0;
   logic [15:0] cmp1;
   logic [31:0] mask;
   logic [31:0] status;
   logic        rx_en;
   logic        tx_en;
   logic        rx_dis_pend;
   logic        tx_dis_pend;
   logic        receive_frame_sync_flag_f;
   logic        transmit_frame_sync_flag_f;
   logic        cp0_f;
   logic        cp1_f;
   logic        ovr_f;
   logic        receive_ready_flag_f;
   logic        thr_full;
   logic        txc_prev;
   logic        txs_prev;
   logic        tx_rise;
   logic        tx_fall;
   logic        tx_frame;
   logic        tx_move;
   logic        rx_take;
   logic        wr_cmd;
   logic        wr_thr;
   logic        rd_sr;
   logic        rd_rhr;
   logic [4:0]  tx_cnt;
   logic [4:0]  tx_len;
   logic [3:0]  tx_slen;
   ssc_tx_e     tx_state;

   // ======================================
   // link pins, all sampled through three flops
   assign pins = {rx_clock_in, rx_sync_in, rx_data_in, tx_clock_in, tx_sync_in};

   ssc_sync #(
      .W (5)
   ) u_sync (
      .clk_in     (clk_in),
      .sys_rst_in (sys_rst_in),
      .ce_in      (ce_in),
      .d_in       (pins),
      .q_out      ({rxc_l, rxs_l, rxd_l, txc_l, txs_l})
   );

   ssc_rx u_rx (
      .clk_in        (clk_in),
      .sys_rst_in    (sys_rst_in),
      .ce_in         (ce_in),
      .en_in         (rx_en),
      .clk_lvl_in    (rxc_l),
      .sync_lvl_in   (rxs_l),
      .data_lvl_in   (rxd_l),
      .len_in        (rfm[`SSC_LEN_HI:0]),
      .word_out      (rx_sr),
      .load_out      (rx_load),
      .sync_word_out (rx_sync_word),
      .frame_out     (rx_frame),
      .busy_out      (rx_busy)
   );

   // ======================================
   // bus decode
   assign wr_cmd  = acc(wr_en_in, addr_in, `SSC_CMD_OFS);
   assign wr_thr  = acc(wr_en_in, addr_in, `SSC_TXW_OFS);
   assign rd_sr   = acc(rd_en_in, addr_in, `SSC_SR_OFS);
   assign rd_rhr  = acc(rd_en_in, addr_in, `SSC_RXW_OFS);
   assign rx_take = rx_load && rx_en;
   assign tx_len  = tfm[`SSC_LEN_HI:0];
   assign tx_slen = tfm[`SSC_SLEN_HI:`SSC_SLEN_LO];

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         rfm                <= `SSC_RST_WORD;
         tfm                <= `SSC_RST_WORD;
         transmit_sync_word <= `SSC_RST_HALF;
         cmp0               <= `SSC_RST_HALF;
         cmp1               <= `SSC_RST_HALF;
      end else if (ce_in && wr_en_in) begin
         unique case (addr_in)
            `SSC_RFM_OFS: rfm                <= wr_data_in;
            `SSC_TFM_OFS: tfm                <= wr_data_in;
            `SSC_TSW_OFS: transmit_sync_word <= wr_data_in[15:0];
            `SSC_RC0_OFS: cmp0               <= wr_data_in[15:0];
            `SSC_RC1_OFS: cmp1               <= wr_data_in[15:0];
            default: ;
         endcase
      end
   end

   // ======================================
   // enable flags; a disable waits for the side to go idle
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         rx_en       <= 1'b0;
         rx_dis_pend <= 1'b0;
      end else if (ce_in) begin
         if (wr_cmd && wr_data_in[`SSC_CMD_RECEIVER_DISABLE_CMD]) begin
            rx_dis_pend <= 1'b1;
         end else if (wr_cmd && wr_data_in[`SSC_CMD_RECEIVER_ENABLED]) begin
            rx_en       <= 1'b1;                                 // [RL3]
            rx_dis_pend <= 1'b0;
         end else if (rx_dis_pend && !rx_busy) begin
            rx_en       <= 1'b0;                                 // [RL3]
            rx_dis_pend <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         tx_en       <= 1'b0;
         tx_dis_pend <= 1'b0;
      end else if (ce_in) begin
         if (wr_cmd && wr_data_in[`SSC_CMD_TRANSMITTER_DISABLE_CMD]) begin
            tx_dis_pend <= 1'b1;
         end else if (wr_cmd && wr_data_in[`SSC_CMD_TRANSMITTER_ENABLED]) begin
            tx_en       <= 1'b1;                                 // [RL4]
            tx_dis_pend <= 1'b0;
         end else if (tx_dis_pend && tx_state == TX_IDLE) begin
            tx_en       <= 1'b0;                                 // [RL4]
            tx_dis_pend <= 1'b0;
         end
      end
   end

   // ======================================
   // receive holding and event flags; a set in the read cycle wins
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         receive_word <= `SSC_RST_WORD;
      end else if (ce_in && rx_take) begin
         receive_word <= rx_sr;                                  // [RL1]
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         receive_ready_flag_f <= 1'b0;
         ovr_f   <= 1'b0;
      end else if (ce_in) begin
         receive_ready_flag_f <= rx_take | (receive_ready_flag_f & ~rd_rhr);               // [RL10]
         ovr_f   <= (rx_take & receive_ready_flag_f) | (ovr_f & ~rd_sr);      // [RL9]
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         receive_frame_sync_flag_f <= 1'b0;
         transmit_frame_sync_flag_f <= 1'b0;
         cp0_f   <= 1'b0;
         cp1_f   <= 1'b0;
      end else if (ce_in) begin
         receive_frame_sync_flag_f <= rx_frame | (receive_frame_sync_flag_f & ~rd_sr);               // [RL5]
         transmit_frame_sync_flag_f <= tx_frame | (transmit_frame_sync_flag_f & ~rd_sr);               // [RL6]
         cp0_f   <= (rx_take & word_hit(rx_sr, cmp0)) | (cp0_f & ~rd_sr); // [RL8]
         cp1_f   <= (rx_take & word_hit(rx_sr, cmp1)) | (cp1_f & ~rd_sr); // [RL7]
      end
   end

   // ======================================
   // transmit holding register
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         transmit_word <= `SSC_RST_WORD;
         thr_full      <= 1'b0;
      end else if (ce_in) begin
         if (wr_thr) begin
            transmit_word <= wr_data_in;                         // [RL2]
         end
         thr_full <= wr_thr | (thr_full & ~tx_move);             // [RL12]
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         shifter <= `SSC_RST_WORD;
      end else if (ce_in && tx_move) begin
         shifter <= transmit_word;
      end
   end

   // ======================================
   // transmit link edges; data changes on falling link clock edges
   assign tx_rise  = txc_l & ~txc_prev;
   assign tx_fall  = ~txc_l & txc_prev;
   assign tx_frame = tx_rise & txs_l & ~txs_prev;
   assign tx_move  = thr_full && ((tx_state == TX_IDLE && tx_frame && tx_en &&
                     !tfm[`SSC_SYNC_DATA_ENABLE]) || (tx_state == TX_SYNC && tx_fall &&
                     tx_cnt == 5'h00));

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         txc_prev <= 1'b0;
         txs_prev <= 1'b0;
      end else if (ce_in) begin
         txc_prev <= txc_l;
         if (tx_rise) begin
            txs_prev <= txs_l;
         end
      end
   end

   // one word per frame keeps the shifter simple; the last bit holds a full period
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         tx_state    <= TX_IDLE;
         tx_cnt      <= 5'h00;
         tx_data_out <= 1'b0;
      end else if (ce_in) begin
         unique case (tx_state)
            TX_IDLE: begin
               if (tx_frame && tx_en && tfm[`SSC_SYNC_DATA_ENABLE]) begin
                  tx_state <= TX_SYNC;
                  tx_cnt   <= {1'b0, tx_slen};
               end else if (tx_move) begin
                  tx_state <= TX_DATA;
                  tx_cnt   <= tx_len;                            // [RL17]
               end
            end
            TX_SYNC: begin
               if (tx_fall) begin
                  tx_data_out <= transmit_sync_word[tx_cnt[3:0]]; // [RL16]
                  if (tx_cnt == 5'h00) begin
                     tx_state <= tx_move ? TX_DATA : TX_LAST;
                     tx_cnt   <= tx_len;                         // [RL17]
                  end else begin
                     tx_cnt <= tx_cnt - 5'h01;
                  end
               end
            end
            TX_DATA: begin
               if (tx_fall) begin
                  tx_data_out <= shifter[tx_cnt];                // [RL2]
                  if (tx_cnt == 5'h00) begin
                     tx_state <= TX_LAST;
                  end else begin
                     tx_cnt <= tx_cnt - 5'h01;
                  end
               end
            end
            TX_LAST: begin
               if (tx_fall) begin
                  tx_data_out <= 1'b0;
                  tx_state    <= TX_IDLE;
               end
            end
         endcase
      end
   end

   // ======================================
   // status, mask and interrupt
   always_comb begin
      status                = '0;
      status[`SSC_SR_TRANSMIT_READY_FLAG] = !thr_full;                          // [RL12]
      status[`SSC_SR_TXEMP] = !thr_full && tx_state == TX_IDLE;   // [RL11]
      status[`SSC_SR_RECEIVE_READY_FLAG] = receive_ready_flag_f;
      status[`SSC_SR_RECEIVE_OVERRUN_FLAG] = ovr_f;
      status[`SSC_SR_CP0]   = cp0_f;
      status[`SSC_SR_CP1]   = cp1_f;
      status[`SSC_SR_TRANSMIT_FRAME_SYNC_FLAG] = transmit_frame_sync_flag_f;
      status[`SSC_SR_RECEIVE_FRAME_SYNC_FLAG] = receive_frame_sync_flag_f;
      status[`SSC_SR_TRANSMITTER_ENABLED]  = tx_en;
      status[`SSC_SR_RECEIVER_ENABLED]  = rx_en;
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         mask <= `SSC_RST_WORD;
      end else if (ce_in) begin
         if (acc(wr_en_in, addr_in, `SSC_IES_OFS)) begin
            mask <= mask | (wr_data_in & `SSC_IRQ_BITS);         // [RL13]
         end else if (acc(wr_en_in, addr_in, `SSC_IEC_OFS)) begin
            mask <= mask & ~wr_data_in;                          // [RL14]
         end
      end
   end

   assign irq_out = |(status & mask);                             // [RL15] [RL18]

   // read data stand one cycle after the strobe; unmapped reads give zero
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         rd_data_out <= `SSC_RST_WORD;
      end else if (ce_in) begin
         rd_data_out <= `SSC_RST_WORD;
         if (rd_en_in) begin
            unique case (addr_in)
               `SSC_RFM_OFS: rd_data_out <= rfm;
               `SSC_TFM_OFS: rd_data_out <= tfm;
               `SSC_RXW_OFS: rd_data_out <= receive_word;
               `SSC_RSW_OFS: rd_data_out <= {16'h0000, rx_sync_word};
               `SSC_TSW_OFS: rd_data_out <= {16'h0000, transmit_sync_word};
               `SSC_RC0_OFS: rd_data_out <= {16'h0000, cmp0};
               `SSC_RC1_OFS: rd_data_out <= {16'h0000, cmp1};
               `SSC_SR_OFS:  rd_data_out <= status;
               `SSC_IEM_OFS: rd_data_out <= mask;                // [RL15]
               default: ;
            endcase
         end
      end
   end

   // ======================================
   // checks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (sys_rst_in || !ce_in);

   property p_rx_ready;
      rx_take |=> status[`SSC_SR_RECEIVE_READY_FLAG] && receive_word == $past(rx_sr);
   endproperty
   a_rx_ready: assert property (p_rx_ready) else $error("receive ready not raised"); // [RL10]

   property p_overrun;
      rx_take && receive_ready_flag_f && !rd_rhr |=> ovr_f;
   endproperty
   a_overrun: assert property (p_overrun) else $error("overrun missed"); // [RL9]

   property p_receive_frame_sync_flag_clear;
      rd_sr && !rx_frame |=> !receive_frame_sync_flag_f;
   endproperty
   a_receive_frame_sync_flag_clear: assert property (p_receive_frame_sync_flag_clear) else $error("rx sync not cleared"); // [RL5]

   property p_mask_set;
      acc(wr_en_in, addr_in, `SSC_IES_OFS) |=>
         (mask & $past(wr_data_in & `SSC_IRQ_BITS)) == $past(wr_data_in & `SSC_IRQ_BITS);
   endproperty
   a_mask_set: assert property (p_mask_set) else $error("mask bit not set"); // [RL13]

   property p_mask_clr;
      acc(wr_en_in, addr_in, `SSC_IEC_OFS) |=>
         (mask & $past(wr_data_in)) == '0 && (mask | $past(wr_data_in)) == ($past(mask) | $past(wr_data_in));
   endproperty
   a_mask_clr: assert property (p_mask_clr) else $error("mask clear wrong"); // [RL14]

   property p_irq_off;
      acc(wr_en_in, addr_in, `SSC_IEC_OFS) && (&wr_data_in[11:0]) |=> !irq_out;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("irq high with mask clear"); // [RL18]

   property p_tx_ready;
      wr_thr |=> !status[`SSC_SR_TRANSMIT_READY_FLAG] ##1 $stable(shifter) || $past(tx_move);
   endproperty
   a_tx_ready: assert property (p_tx_ready) else $error("tx ready after load"); // [RL12]

   property p_drained;
      tx_state == TX_DATA || tx_state == TX_LAST |-> !status[`SSC_SR_TXEMP];
   endproperty
   a_drained: assert property (p_drained) else $error("drained while shifting"); // [RL11]

   property p_rx_en;
      wr_cmd && wr_data_in[`SSC_CMD_RECEIVER_ENABLED] && !wr_data_in[`SSC_CMD_RECEIVER_DISABLE_CMD] |=> rx_en [*2];
   endproperty
   a_rx_en: assert property (p_rx_en) else $error("rx enable not set"); // [RL3]

   property p_tx_en;
      tx_en && tx_dis_pend ##1 !tx_en |-> $past(tx_state) == TX_IDLE;
   endproperty
   a_tx_en: assert property (p_tx_en) else $error("tx enable dropped early"); // [RL4]

   property p_len;
      tx_move |=> tx_cnt == $past(tx_len) && shifter == $past(transmit_word);
   endproperty
   a_len: assert property (p_len) else $error("word length not loaded"); // [RL17]

endmodule

// File: rtl/ssc_pkg.sv
package ssc_pkg;

   typedef enum logic [3:0] {
      TX_IDLE = 4'b0001,
      TX_SYNC = 4'b0010,
      TX_DATA = 4'b0100,
      TX_LAST = 4'b1000
   } ssc_tx_e;

endpackage

// File: rtl/ssc_rx.sv
`timescale 1ns/1ns
`include "ssc_consts.svh"

// ======================================
// receive deserialiser, samples on link clock rising edges
module ssc_rx (
   input  wire logic        clk_in,
   input  wire logic        sys_rst_in,
   input  wire logic        ce_in,
   input  wire logic        en_in,
   input  wire logic        clk_lvl_in,
   input  wire logic        sync_lvl_in,
   input  wire logic        data_lvl_in,
   input  wire logic [4:0]  len_in,
   output logic      [31:0] word_out,
   output logic             load_out,
   output logic      [15:0] sync_word_out,
   output logic             frame_out,
   output logic             busy_out
);

   logic       clk_prev;
   logic       sync_prev;
   logic       rise;
   logic [4:0] cnt;
   logic [15:0] ssr;

   assign rise      = clk_lvl_in & ~clk_prev;
   assign frame_out = rise & sync_lvl_in & ~sync_prev;

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         clk_prev  <= 1'b0;
         sync_prev <= 1'b0;
      end else if (ce_in) begin
         clk_prev <= clk_lvl_in;
         if (rise) begin
            sync_prev <= sync_lvl_in;
         end
      end
   end

   // bits seen while frame sync is high form the sync word
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         ssr           <= `SSC_RST_HALF;
         sync_word_out <= `SSC_RST_HALF;
      end else if (ce_in && rise) begin
         if (sync_lvl_in && !sync_prev) begin
            ssr <= {15'h0000, data_lvl_in};
         end else if (sync_lvl_in) begin
            ssr <= {ssr[14:0], data_lvl_in};
         end else if (sync_prev) begin
            sync_word_out <= ssr;
         end
      end
   end

   // shifting in at bit 0 keeps the word right-justified for any length
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         word_out <= `SSC_RST_WORD;
         cnt      <= 5'h00;
         busy_out <= 1'b0;
         load_out <= 1'b0;
      end else if (ce_in) begin
         load_out <= 1'b0;
         if (rise && !sync_lvl_in && sync_prev && en_in) begin
            word_out <= {31'h00000000, data_lvl_in};  // [RL1]
            cnt      <= len_in;                       // [RL17]
            busy_out <= (len_in != 5'h00);
            load_out <= (len_in == 5'h00);
         end else if (rise && busy_out) begin
            word_out <= {word_out[30:0], data_lvl_in}; // [RL1]
            cnt      <= cnt - 5'h01;
            if (cnt == 5'h01) begin
               busy_out <= 1'b0;
               load_out <= 1'b1;
            end
         end
      end
   end

endmodule

// File: rtl/ssc_sync.sv
`timescale 1ns/1ns

// ======================================
// three-stage pin synchroniser, output moves once stages two and three agree
module ssc_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_in,
   input  wire logic         sys_rst_in,
   input  wire logic         ce_in,
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);

   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
      end else if (ce_in) begin
         s1 <= d_in;
         s2 <= s1;
         s3 <= s2;
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         q_out <= '0;
      end else if (ce_in) begin
         q_out <= (s2 & ~(s2 ^ s3)) | (q_out & (s2 ^ s3));
      end
   end

endmodule
